// ==== shared/edc_params.svh ====
// Offsets, field positions, reset values for the extended device control block.
// Included by the package and by every design file that needs a figure.
`ifndef EDC_PARAMS_SVH
`define EDC_PARAMS_SVH

`define EDC_AW              8
`define EDC_DW              32
`define EDC_OFF_EXT_CTRL    8'h18

`define EDC_B_EN_LO         0
`define EDC_B_EN_HI         3
`define EDC_B_PIN4          4
`define EDC_B_PHY_INTERRUPT_LEVEL        5
`define EDC_B_VAL0          6
`define EDC_B_VAL1          7
`define EDC_B_RSV_LO        8
`define EDC_B_RSV_HI        9
`define EDC_B_DIR0          10
`define EDC_B_DIR1          11
`define EDC_B_SPD_TRIG      12
`define EDC_B_NVM_TRIG      13
`define EDC_B_BYPASS        15
`define EDC_B_RELAXED_ORDER_DISABLE        17

`define EDC_RST_EN          4'h0
`define EDC_RST_VAL         2'h0
`define EDC_RST_RSV98       2'h1
`define EDC_RST_DIR         2'h0
`define EDC_RST_BYPASS      1'h0
`define EDC_RST_RELAXED_ORDER_DISABLE      1'h0
`define EDC_RST_CAUSE       3'h0
`define EDC_RST_RDATA       32'h0000_0000

`define EDC_SYNC_STAGES     2

`endif

// ==== shared/edc_pkg.sv ====
// Types shared by the extended device control block and its helpers.
// Figures live in edc_params.svh; this package only holds types.
`include "edc_params.svh"

package edc_pkg;

    typedef struct packed {
        logic [3:0]  en;
        logic [1:0]  val;
        logic [1:0]  rsv98;
        logic [1:0]  dir;
        logic        bypass;
        logic        relaxed_order_disable;
        logic [2:0]  cause;
        logic [31:0] rdata;
    } edc_ctrl_s;

    typedef struct packed {
        logic pend;
    } edc_trig_s;

    typedef enum logic {
        EDC_WIDE    = 1'b0,
        EDC_REDUCED = 1'b1
    } edc_variant_e;

endpackage

// ==== core/edc_sync.sv ====
// Two-stage level synchroniser for pins and other asynchronous levels.
// Assumes the inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
`include "edc_params.svh"

module edc_sync
    import edc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // First stage feeds the second and nothing else
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// ==== core/edc_trig.sv ====
// Self-clearing trigger: a write of one raises a request that holds until
// the consumer acknowledges it or the gate goes low. Consumer runs on the same clock.
`timescale 1ns/1ps
`include "edc_params.svh"

module edc_trig
    import edc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic set,
    input  wire logic gate,
    input  wire logic ack,
    output logic      req
);

    edc_trig_s st_r;
    edc_trig_s st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // A set in the ack cycle survives, so a quick re-trigger is not lost.
    // With the gate low the request is dropped at once, as if accepted.
    always_comb begin
        st_nxt = st_r;
        if (ack || !gate) begin
            st_nxt.pend = 1'b0;
        end
        if (set && gate) begin
            st_nxt.pend = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req = st_r.pend;

endmodule

// ==== core/edc_top.sv ====
// Extended device control register: pin data and direction, pin interrupt
// routing, speed detection and nonvolatile reload triggers, speed bypass
// and, in the wide variant only, relaxed ordering disable.
// Assumes a same-clock register port and a same-clock reset pulse for
// software and system resets; pins and PHY interrupt arrive asynchronously.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "edc_params.svh"

module edc_top
    import edc_pkg::*;
#(
    parameter edc_variant_e VARIANT = EDC_WIDE,
    parameter int           AW      = `EDC_AW
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          soft_rst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata,
    input  wire logic [1:0]    pin_in,
    output logic      [1:0]    pin_out,
    output logic      [1:0]    pin_oe,
    input  wire logic          upper_pin4_in,
    output logic      [2:0]    pin_interrupt_cause,
    input  wire logic          phy_interrupt_level,
    input  wire logic          nvm_load,
    input  wire logic [1:0]    nvm_pin_value,
    input  wire logic [1:0]    nvm_pin_direction,
    output logic               nvm_reload_req,
    input  wire logic          nvm_reload_ack,
    input  wire logic          internal_phy_mode,
    output logic               speed_detect_req,
    input  wire logic          speed_detect_ack,
    input  wire logic          forced_speed_option,
    input  wire logic [1:0]    ctrl_speed,
    output logic               speed_detect_bypass,
    output logic [1:0]         direct_speed,
    output logic               clock_switch_force,
    input  wire logic          pcix_mode,
    input  wire logic          pcix_cmd_relaxed,
    output logic               relaxed_order_req
);

    localparam logic REDUCED = (VARIANT == EDC_REDUCED);

    edc_ctrl_s st_r;
    edc_ctrl_s st_nxt;

    logic [3:0] async_lv;
    logic [3:0] sync_lv;
    logic [1:0] pin_sync;
    logic       pin4_sync;
    logic       phy_int_sync;
    logic       wr_hit;
    logic       rd_hit;
    logic       spd_set;
    logic       nvm_set;
    logic [1:0] pin_rd_lv;
    logic [1:0] pin_cause_lv;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, used by both strobes
    function automatic logic hit(input logic [AW-1:0] a);
        hit = (a == AW'(`EDC_OFF_EXT_CTRL));
    endfunction

    assign wr_hit = reg_wr && hit(reg_addr);
    assign rd_hit = reg_rd && hit(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // Pin and PHY interrupt levels come from outside the clock domain
    assign async_lv = {phy_interrupt_level, upper_pin4_in, pin_in};

    edc_sync #(
        .W (4)
    ) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (async_lv),
        .sync_out (sync_lv)
    );

    assign pin_sync     = sync_lv[1:0];
    assign pin4_sync    = sync_lv[2];
    assign phy_int_sync = sync_lv[3];

    ////////////////////////////////////////////////////////////////////////
    // Both software pins: read-back level and routed interrupt level.
    // Enables 3:2 serve these two pins in either variant.
    for (genvar i = 0; i < 2; i++) begin : g_pin
        assign pin_rd_lv[i]    = st_r.dir[i] ? st_r.val[i] : pin_sync[i];
        // An output pin never raises its own cause
        assign pin_cause_lv[i] = st_r.en[i+2] && !st_r.dir[i] && pin_sync[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // Self-clearing triggers
    assign spd_set = wr_hit && reg_wdata[`EDC_B_SPD_TRIG];
    assign nvm_set = wr_hit && reg_wdata[`EDC_B_NVM_TRIG];

    // Outside internal PHY mode the request is swallowed, not queued
    edc_trig u_spd_trig (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set     (spd_set),
        .gate    (internal_phy_mode),
        .ack     (speed_detect_ack),
        .req     (speed_detect_req)
    );

    // Software must have quiesced the device first; nothing here checks it
    edc_trig u_nvm_trig (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set     (nvm_set),
        .gate    (1'b1),
        .ack     (nvm_reload_ack),
        .req     (nvm_reload_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read image of the register
    function automatic logic [31:0] read_image(input edc_ctrl_s s,
                                               input logic [1:0] pins,
                                               input logic phy,
                                               input logic spd_p,
                                               input logic nvm_p);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (REDUCED) begin
            v[`EDC_B_EN_HI:`EDC_B_EN_HI-1] = s.en[3:2];
        end else begin
            v[`EDC_B_EN_HI:`EDC_B_EN_LO] = s.en;
            v[`EDC_B_PHY_INTERRUPT_LEVEL] = phy;
            v[`EDC_B_RELAXED_ORDER_DISABLE] = s.relaxed_order_disable;
        end
        v[`EDC_B_PIN4] = 1'b0;
        v[`EDC_B_VAL0] = pins[0];
        v[`EDC_B_VAL1] = pins[1];
        v[`EDC_B_RSV_HI:`EDC_B_RSV_LO] = s.rsv98;
        v[`EDC_B_DIR0] = s.dir[0];
        v[`EDC_B_DIR1] = s.dir[1];
        v[`EDC_B_SPD_TRIG] = spd_p;
        v[`EDC_B_NVM_TRIG] = nvm_p;
        v[`EDC_B_BYPASS] = s.bypass;
        read_image = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;

        // Software register writes
        if (wr_hit) begin
            if (REDUCED) begin
                st_nxt.en = {reg_wdata[`EDC_B_EN_HI:`EDC_B_EN_HI-1], 2'h0};
                st_nxt.relaxed_order_disable = 1'b0;
            end else begin
                st_nxt.en = reg_wdata[`EDC_B_EN_HI:`EDC_B_EN_LO];
                st_nxt.relaxed_order_disable = reg_wdata[`EDC_B_RELAXED_ORDER_DISABLE];
            end
            st_nxt.val[0] = reg_wdata[`EDC_B_VAL0];
            st_nxt.val[1] = reg_wdata[`EDC_B_VAL1];
            st_nxt.rsv98  = reg_wdata[`EDC_B_RSV_HI:`EDC_B_RSV_LO];
            st_nxt.dir[0] = reg_wdata[`EDC_B_DIR0];
            st_nxt.dir[1] = reg_wdata[`EDC_B_DIR1];
            st_nxt.bypass = reg_wdata[`EDC_B_BYPASS];
        end

        // Nonvolatile load overrides a write in the same cycle
        if (nvm_load) begin
            st_nxt.val = nvm_pin_value;
            st_nxt.dir = nvm_pin_direction;
        end

        // Soft reset clears everything except the pin directions, the read data and the two pending trigger requests
        if (soft_rst) begin
            st_nxt.en     = `EDC_RST_EN;
            st_nxt.val    = `EDC_RST_VAL;
            st_nxt.rsv98  = `EDC_RST_RSV98;
            st_nxt.bypass = `EDC_RST_BYPASS;
            st_nxt.relaxed_order_disable = `EDC_RST_RELAXED_ORDER_DISABLE;
            st_nxt.cause  = `EDC_RST_CAUSE;
        end

        // Pin interrupt causes follow the sampled pin while routed
        if (REDUCED) begin
            st_nxt.cause[0] = 1'b0;
        end else begin
            // Pin 4 shares its direction with bit 8, held at one by software
            st_nxt.cause[0] = st_r.en[0] && !st_r.rsv98[0] && pin4_sync;
        end
        st_nxt.cause[2:1] = pin_cause_lv;
        if (soft_rst) begin
            st_nxt.cause = `EDC_RST_CAUSE;
        end

        // Read data stand only in the cycle after the strobe
        st_nxt.rdata = `EDC_RST_RDATA;
        if (rd_hit) begin
            st_nxt.rdata = read_image(st_r, pin_rd_lv, phy_int_sync,
                                      speed_detect_req, nvm_reload_req);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only power-on reset touches the pin directions
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r.en     <= `EDC_RST_EN;
            st_r.val    <= `EDC_RST_VAL;
            st_r.rsv98  <= `EDC_RST_RSV98;
            st_r.dir    <= `EDC_RST_DIR;
            st_r.bypass <= `EDC_RST_BYPASS;
            st_r.relaxed_order_disable <= `EDC_RST_RELAXED_ORDER_DISABLE;
            st_r.cause  <= `EDC_RST_CAUSE;
            st_r.rdata  <= `EDC_RST_RDATA;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata           = st_r.rdata;
    assign pin_out             = st_r.val;
    assign pin_oe              = st_r.dir;
    assign pin_interrupt_cause = st_r.cause;

    // Bypass hands the control speed straight on, no clock switching
    assign speed_detect_bypass = st_r.bypass;
    assign direct_speed        = st_r.bypass ? ctrl_speed : 2'h0;
    assign clock_switch_force  = forced_speed_option && !st_r.bypass;

    assign relaxed_order_req   = pcix_mode && pcix_cmd_relaxed
                                 && !st_r.relaxed_order_disable;

endmodule

// ==== bench/edc_top_sva.sv ====
// Checker for the extended device control block.
// Sees only edc_top ports; bound from the bench top file.
`timescale 1ns/1ps
`include "edc_params.svh"

module edc_top_sva
    import edc_pkg::*;
#(
    parameter int AW = `EDC_AW
) (
    input wire logic          ref_clk,
    input wire logic          nrst,
    input wire logic          soft_rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0]   reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [31:0]   reg_rdata,
    input wire logic [1:0]    pin_out,
    input wire logic [1:0]    pin_oe,
    input wire logic [2:0]    pin_interrupt_cause,
    input wire logic          nvm_load,
    input wire logic          nvm_reload_req,
    input wire logic          nvm_reload_ack,
    input wire logic          internal_phy_mode,
    input wire logic          speed_detect_req,
    input wire logic [1:0]    ctrl_speed,
    input wire logic          forced_speed_option,
    input wire logic          speed_detect_bypass,
    input wire logic [1:0]    direct_speed,
    input wire logic          clock_switch_force,
    input wire logic          pcix_mode,
    input wire logic          pcix_cmd_relaxed,
    input wire logic          relaxed_order_req
);
////////////////////////////////////////
    logic w18;
    logic ro_r;
    assign w18 = reg_wr && reg_addr == `EDC_OFF_EXT_CTRL && !soft_rst && !nvm_load;
    // Mirror of the ordering disable bit, which the design keeps internal
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            ro_r <= 1'h0;
        else if (soft_rst)
            ro_r <= 1'h0;
        else if (reg_wr && reg_addr == `EDC_OFF_EXT_CTRL)
            ro_r <= reg_wdata[`EDC_B_RELAXED_ORDER_DISABLE];
    end
////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_rsv_zero: assert property (reg_rd |=> (reg_rdata & 32'hFFFD_4010) == 32'h0)
        else $error("reserved read bits not zero");
    a_val_write: assert property (w18 |=> pin_out == $past(reg_wdata[7:6]))
        else $error("pin drive level not taken from write");
    a_dir_write: assert property (w18 |=> pin_oe == $past(reg_wdata[11:10]))
        else $error("pin direction not taken from write");
    a_dir_soft: assert property (soft_rst && !reg_wr && !nvm_load |=> $stable(pin_oe))
        else $error("soft reset changed pin direction");
    a_bypass_write: assert property (w18 |=> speed_detect_bypass == $past(reg_wdata[15]))
        else $error("bypass not taken from write");
    a_direct_speed: assert property (
        direct_speed == (speed_detect_bypass ? ctrl_speed : 2'h0))
        else $error("direct speed wrong");
    a_clk_switch: assert property (
        clock_switch_force == (forced_speed_option && !speed_detect_bypass))
        else $error("clock switch force wrong");
    a_relax_req: assert property (
        relaxed_order_req == (pcix_mode && pcix_cmd_relaxed && !ro_r))
        else $error("relaxed order request wrong");
    a_nvm_set: assert property (w18 && reg_wdata[`EDC_B_NVM_TRIG] |=> nvm_reload_req)
        else $error("reload request not raised");
    a_nvm_clear: assert property (nvm_reload_ack && !w18 |=> !nvm_reload_req)
        else $error("reload request not cleared by ack");
    a_spd_set: assert property (
        w18 && reg_wdata[12] && internal_phy_mode |=> speed_detect_req)
        else $error("speed detect request not raised");
    a_spd_mode: assert property (!internal_phy_mode [*2] |-> !speed_detect_req)
        else $error("speed detect request outside internal mode");
    a_cause_out: assert property (pin_oe[0] [*2] |-> !pin_interrupt_cause[1])
        else $error("cause raised from an output pin");
    c_reload: cover property (nvm_reload_req && nvm_reload_ack);
    c_cause: cover property (pin_interrupt_cause == 3'h6);
    c_relax: cover property (relaxed_order_req);
endmodule

// ==== bench/edc_top_bench.sv ====
// Self-checking bench for the extended device control block, wide variant.
// Drives every port itself; read results are queued and checked a cycle later.
`timescale 1ns/1ps
`include "edc_params.svh"

module edc_top_bench
    import edc_pkg::*;
;
    logic        ref_clk, nrst, soft_rst, reg_wr, reg_rd, upper_pin4_in, rd_p;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, e;
    logic [1:0]  pin_in, pin_out, pin_oe, nvm_pin_value, nvm_pin_direction;
    logic [1:0]  ctrl_speed, direct_speed;
    logic [2:0]  pin_interrupt_cause;
    logic        phy_interrupt_level, nvm_load, nvm_reload_req, nvm_reload_ack;
    logic        internal_phy_mode, speed_detect_req, speed_detect_ack;
    logic        forced_speed_option, speed_detect_bypass, clock_switch_force;
    logic        pcix_mode, pcix_cmd_relaxed, relaxed_order_req;
    logic [31:0] exp_q[$];
    int          fail_count = 0;
    int          compares   = 0;
    int          cyc        = 0;
    int          seed       = 32'h9F04_2002;

    edc_top #(.VARIANT(EDC_WIDE), .AW(8)) dut (.*);
////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Each access leaves one idle cycle so a strobe is never set twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        exp_q.push_back(x);
        @(posedge ref_clk);
        reg_rd <= 1'h0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
////////////////////////////////////////
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        {pcix_mode, pcix_cmd_relaxed, forced_speed_option, ctrl_speed} <= 5'($random(seed));
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end
    always @(posedge ref_clk) rd_p <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_p)
            check(reg_rdata, exp_q.pop_front());
    end
////////////////////////////////////////
    initial begin
        {nrst, soft_rst, reg_wr, reg_rd, nvm_load, nvm_reload_ack, speed_detect_ack,
         upper_pin4_in, phy_interrupt_level} = '0;
        reg_addr          = 8'h00;
        reg_wdata         = 32'h0;
        pin_in            = 2'h0;
        nvm_pin_value     = 2'h1;
        nvm_pin_direction = 2'h3;
        internal_phy_mode = 1'h1;
        idle(16);
        nrst <= 1'h1;
        rd(8'h18, 32'h0000_0100);
        phy_interrupt_level <= 1'h1;
        nvm_load <= 1'h1;
        @(posedge ref_clk);
        nvm_load <= 1'h0;
        idle(3);
        rd(8'h18, 32'h0000_0D60);
        wr(8'h18, 32'h0002_BDFF);
        rd(8'h18, 32'h0002_BDEF);
        nvm_reload_ack   <= 1'h1;
        speed_detect_ack <= 1'h1;
        @(posedge ref_clk);
        nvm_reload_ack   <= 1'h0;
        speed_detect_ack <= 1'h0;
        rd(8'h18, 32'h0002_8DEF);
        soft_rst <= 1'h1;
        @(posedge ref_clk);
        soft_rst <= 1'h0;
        rd(8'h18, 32'h0000_0D20);
        internal_phy_mode <= 1'h0;
        wr(8'h18, 32'h0000_1D00);
        rd(8'h18, 32'h0000_0D20);
        internal_phy_mode <= 1'h1;
        wr(8'h18, 32'h0000_1D00);
        rd(8'h18, 32'h0000_1D20);
        // Dropping internal mode must withdraw the pending detection request
        internal_phy_mode <= 1'h0;
        idle(3);
        internal_phy_mode <= 1'h1;
        pin_in <= 2'h3;
        wr(8'h18, 32'h0000_010C);
        idle(4);
        @(negedge ref_clk);
        check(32'(pin_interrupt_cause), 32'h6);
        rd(8'h18, 32'h0000_01EC);
        wr(8'h18, 32'h0000_0D0C);
        idle(4);
        @(negedge ref_clk);
        check(32'(pin_interrupt_cause), 32'h0);
        rd(8'h1C, 32'h0);
        pin_in <= 2'h1;
        repeat (24) begin
            d = $random(seed) & 32'h0002_8CCF | 32'h0000_0100;
            e = d | 32'h0000_0020;
            for (int i = 0; i < 2; i++) begin
                if (!d[10 + i])
                    e[6 + i] = (i == 0);
            end
            wr(8'h18, d);
            rd(8'h18, e);
        end
        // Power-on reset is the only reset that clears the directions;
        // let the last read data be checked before the reset wipes them
        idle(1);
        nrst <= 1'h0;
        idle(2);
        nrst <= 1'h1;
        idle(3);
        rd(8'h18, 32'h0000_0160);
        idle(4);
        give_verdict();
    end
endmodule

bind edc_top edc_top_sva #(.AW(AW)) u_sva (.*);
